/* sensor_host.sv */
// Serial bus host that performs word writes and word reads on the temperature sensor.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "sensor_host_map.svh"

module sensor_host #(
   parameter int QUARTER_CYCLES = `SCL_QUARTER_CYCLES
) (
   input  wire logic                        ref_clk,
   input  wire logic                        reset,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        scl_in,
   output logic                             scl_out,
   output logic                             scl_oe,
   input  wire logic                        sda_in,
   output logic                             sda_out,
   output logic                             sda_oe
);
   import sensor_host_pkg::*;

   // --------------------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------------------
   // Both stages reset to the idle high level so that leaving reset cannot fake a start.
   logic [1:0] sda_sync;
   logic [1:0] scl_sync;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sda_sync <= 2'b11;
         scl_sync <= 2'b11;
      end else begin
         sda_sync <= {sda_sync[0], sda_in};
         scl_sync <= {scl_sync[0], scl_in};
      end
   end
   wire sda_s = sda_sync[1];

   // --------------------------------------------------------------------------
   // APB register file
   // --------------------------------------------------------------------------
   logic        go_req;
   logic        op_read;
   logic [2:0]  dev_sel;
   byte_t       cmd_code;
   logic [15:0] wr_word;
   logic [15:0] rd_word;
   logic        busy;
   logic        done_flag;
   logic        nack_flag;
   logic        finish;
   logic        got_nack;
   wire         apb_wr = psel && penable && pwrite;
   wire         apb_rd = psel && penable && !pwrite;

   // Zero wait states: the access phase completes at its first edge.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && paddr != `HOST_CTRL_OFFSET && paddr != `HOST_WDATA_OFFSET
                    && paddr != `HOST_STATUS_OFFSET && paddr != `HOST_RDATA_OFFSET;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         op_read  <= 1'b0;
         dev_sel  <= 3'h0;
         cmd_code <= 8'h00;
         wr_word  <= 16'h0000;
      end else if (apb_wr && pready && paddr == `HOST_CTRL_OFFSET && !busy) begin
         op_read  <= pwdata[`CTRL_READ_BIT];
         dev_sel  <= pwdata[`CTRL_SEL_LSB +: 3];
         cmd_code <= pwdata[`CTRL_CMD_LSB +: 8];
      end else if (apb_wr && pready && paddr == `HOST_WDATA_OFFSET && !busy) begin
         wr_word  <= pwdata[15:0];
      end
   end

   // A start request while busy is ignored so a transfer is never cut short.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         go_req <= 1'b0;
      end else begin
         go_req <= apb_wr && pready && paddr == `HOST_CTRL_OFFSET && !busy && pwdata[`CTRL_GO_BIT];
      end
   end

   // --------------------------------------------------------------------------
   // Status flags
   // --------------------------------------------------------------------------
   // Completion wins over a software clear in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         done_flag <= 1'b0;
         nack_flag <= 1'b0;
      end else if (finish) begin
         done_flag <= 1'b1;
         nack_flag <= got_nack;
      end else if (go_req) begin
         done_flag <= 1'b0;
         nack_flag <= 1'b0;
      end
   end

   // --------------------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------------------
   // Read data is taken in the setup cycle so it stands for the single access cycle.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd && !pready) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `HOST_CTRL_OFFSET:   prdata <= {16'h0000, cmd_code, 1'b0, dev_sel, 2'b00, op_read, 1'b0};
            `HOST_WDATA_OFFSET:  prdata <= {16'h0000, wr_word};
            `HOST_STATUS_OFFSET: prdata <= {29'h0, nack_flag, done_flag, busy};
            `HOST_RDATA_OFFSET:  prdata <= {16'h0000, rd_word};
            default:             prdata <= 32'h0000_0000;
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Serial engine
   // --------------------------------------------------------------------------
   // Each bit is four quarter periods: low/change, low, high/sample, high.
   host_state_e state;
   logic [15:0] qcnt;
   logic [1:0]  phase;
   logic [3:0]  bitn;
   logic [2:0]  byten;
   byte_t       shreg;
   logic        restarted;
   wire         tick = (qcnt == 16'(QUARTER_CYCLES - 1));
   // Clock stretching: a held-low clock pauses the high phase.
   wire         stalled = (phase == 2'd2) && !scl_sync[1] && !scl_oe;

   always_ff @(posedge ref_clk) begin
      if (reset || state == ST_IDLE || tick) begin
         qcnt <= 16'h0000;
      end else if (!stalled) begin
         qcnt <= qcnt + 16'h0001;
      end
   end

   // Byte order: 0 address(w), 1 command, 2 MSB, 3 LSB; read: 2 address(r), 3 MSB, 4 LSB.
   function automatic byte_t tx_byte(input logic [2:0] n);
      byte_t b;
      b = 8'h00;
      unique case (n)
         3'd0:    b = {`SENS_ADDR_PREFIX, dev_sel, 1'b0};
         3'd1:    b = cmd_code;
         3'd2:    b = op_read ? {`SENS_ADDR_PREFIX, dev_sel, 1'b1} : wr_word[15:8];
         default: b = wr_word[7:0];
      endcase
      return b;
   endfunction

   wire receiving = op_read && restarted && byten != 3'd2;
   wire last_byte = op_read ? (restarted && byten == 3'd4) : (byten == 3'd3);

   // --------------------------------------------------------------------------
   // Transfer sequencer
   // --------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state     <= ST_IDLE;
         phase     <= 2'd0;
         bitn      <= 4'd0;
         byten     <= 3'd0;
         shreg     <= 8'h00;
         restarted <= 1'b0;
         busy      <= 1'b0;
         finish    <= 1'b0;
         got_nack  <= 1'b0;
         rd_word   <= 16'h0000;
         scl_oe    <= 1'b0;
         sda_oe    <= 1'b0;
      end else begin
         finish <= 1'b0;
         if (state == ST_IDLE) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            if (go_req) begin
               busy      <= 1'b1;
               got_nack  <= 1'b0;
               restarted <= 1'b0;
               byten     <= 3'd0;
               phase     <= 2'd0;
               state     <= ST_START;
            end
         end else if (tick) begin
            phase <= phase + 2'd1;
            unique case (state)
               ST_START, ST_RESTART: begin
                  // Phase 0 releases data, phase 1 releases the clock, phase 2 pulls data low with clock high.
                  if (phase == 2'd0) sda_oe <= 1'b0;
                  if (phase == 2'd1) scl_oe <= 1'b0;
                  if (phase == 2'd2) sda_oe <= 1'b1;
                  if (phase == 2'd3) begin
                     scl_oe <= 1'b1;
                     shreg  <= tx_byte(byten);
                     bitn   <= 4'd0;
                     state  <= ST_BYTE;
                  end
               end
               ST_BYTE: begin
                  if (phase == 2'd0) sda_oe <= receiving ? 1'b0 : !shreg[7];
                  if (phase == 2'd1) scl_oe <= 1'b0;
                  if (phase == 2'd2 && receiving) rd_word <= {rd_word[14:0], sda_s};
                  if (phase == 2'd3) begin
                     scl_oe <= 1'b1;
                     shreg  <= {shreg[6:0], 1'b0};
                     bitn   <= bitn + 4'd1;
                     if (bitn == 4'd7) state <= ST_ACK;
                  end
               end
               ST_ACK: begin
                  // Host acks MSB and nacks LSB on reads; otherwise listens for the sensor.
                  if (phase == 2'd0) sda_oe <= receiving && !last_byte;
                  if (phase == 2'd1) scl_oe <= 1'b0;
                  if (phase == 2'd2 && !receiving && sda_s) got_nack <= 1'b1;
                  if (phase == 2'd3) begin
                     scl_oe <= 1'b1;
                     byten  <= byten + 3'd1;
                     // A refused byte ends the frame with a stop so the bus is left free.
                     if (got_nack || last_byte) begin
                        state <= ST_STOP;
                     end else if (op_read && !restarted && byten == 3'd1) begin
                        restarted <= 1'b1;
                        state     <= ST_RESTART;
                     end else begin
                        shreg <= tx_byte(byten + 3'd1);
                        bitn  <= 4'd0;
                        state <= ST_BYTE;
                     end
                  end
               end
               ST_STOP: begin
                  if (phase == 2'd0) sda_oe <= 1'b1;
                  if (phase == 2'd1) scl_oe <= 1'b0;
                  if (phase == 2'd2) sda_oe <= 1'b0;
                  if (phase == 2'd3) state <= ST_DONE;
               end
               ST_DONE: begin
                  busy   <= 1'b0;
                  finish <= 1'b1;
                  state  <= ST_IDLE;
               end
               // An illegal state code falls back to idle with both lines released.
               default: begin
                  busy   <= 1'b0;
                  scl_oe <= 1'b0;
                  sda_oe <= 1'b0;
                  state  <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // --------------------------------------------------------------------------
   // Pin drivers
   // --------------------------------------------------------------------------
   // Open-drain: the host only ever drives low.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end
endmodule

/* sensor_host_map.svh */
// Constants for the sensor bus host controller: register offsets, fields and timing counts.
`ifndef SENSOR_HOST_MAP_SVH
`define SENSOR_HOST_MAP_SVH
// -----------------------------------------------------------------------------
// Host command/status registers on APB (byte addresses)
// -----------------------------------------------------------------------------
`define HOST_CTRL_OFFSET      8'h00
`define HOST_WDATA_OFFSET     8'h04
`define HOST_STATUS_OFFSET    8'h08
`define HOST_RDATA_OFFSET     8'h0c
// Control register fields.
`define CTRL_GO_BIT           0
`define CTRL_READ_BIT         1
`define CTRL_SEL_LSB          4
`define CTRL_CMD_LSB          8
// Status register fields.
`define STAT_BUSY_BIT         0
`define STAT_DONE_BIT         1
`define STAT_NACK_BIT         2
// -----------------------------------------------------------------------------
// Sensor register map (command codes)
// -----------------------------------------------------------------------------
`define SENS_CAPABILITY       8'h00
`define SENS_CONFIG           8'h01
`define SENS_ALARM_UPPER      8'h02
`define SENS_ALARM_LOWER      8'h03
`define SENS_CRITICAL         8'h04
`define SENS_TEMPERATURE      8'h05
`define SENS_MAKER_ID         8'h06
`define SENS_PART_ID          8'h07
`define SENS_VENDOR_FIRST     8'h08
`define SENS_VENDOR_LAST      8'h0e
`define SENS_CAPABILITY_POR   16'h0017
`define SENS_ADDR_PREFIX      4'h3
// -----------------------------------------------------------------------------
// Serial timing
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS         8
`define SCL_QUARTER_NS        640
`define SCL_QUARTER_CYCLES    ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* sensor_host_pkg.sv */
// Types shared by the sensor bus host controller.
package sensor_host_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_BYTE, ST_ACK, ST_RESTART, ST_STOP, ST_DONE
   } host_state_e;
   typedef logic [7:0] byte_t;
endpackage

/* sensor_host_props.sv */
// Concurrent checks on the sensor bus host ports.
`timescale 1ns/1ps
module sensor_host_props (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_out,
   input wire logic       sda_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Start and stop are data moves while the host leaves the clock released.
   sequence start_s; $rose(sda_oe) && !scl_oe; endsequence
   sequence stop_s; $fell(sda_oe) && !scl_oe; endsequence
   chk_start_then_clock: assert property (start_s |-> ##[1:1000] $rose(scl_oe))
      else $error("clock not pulled after start");
   chk_stop_bus_idle: assert property (stop_s |=> (!scl_oe && !sda_oe)[*4])
      else $error("bus not idle after stop");
   chk_release_out: assert property ($fell(reset) |-> !scl_oe && !sda_oe)
      else $error("lines held after reset");
   chk_scl_pull_low: assert property (scl_oe |-> !scl_out)
      else $error("clock driven high");
   chk_sda_pull_low: assert property (sda_oe |-> !sda_out)
      else $error("data driven high");
   chk_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
      else $error("slave error wrong");
endmodule
bind sensor_host sensor_host_props props (.ref_clk, .reset, .psel, .penable, .paddr, .pready, .pslverr,
   .scl_out, .scl_oe, .sda_out, .sda_oe);

/* sensor_host_tb.sv */
// Self-checking bench for the sensor bus host with a sensor model on the wires.
`timescale 1ns/1ps
module sensor_host_tb;
   localparam logic [2:0]  SEL = 3'b010;
   localparam logic [15:0] MAKER = 16'h1234; // Arbitrary value.
   localparam logic [15:0] PART = 16'h5678; // Arbitrary value.
   localparam logic [15:0] TEMP = 16'h0190;
   logic        ref_clk, reset, psel, penable, pwrite, slow, pready, pslverr;
   logic        scl_oe, sda_oe, scl_pull, sda_pull;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          err_total, checked;
   // Both lines have pull-ups: released means high.
   wire         scl = !(scl_oe | scl_pull);
   wire         sda = !(sda_oe | sda_pull);
   sensor_host #(.QUARTER_CYCLES(4)) dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe);
   sensor_model #(.MAKER_ID(MAKER), .PART_ID(PART), .TEMP_VALUE(TEMP)) partner (.scl, .sda, .pins(SEL),
      .slow, .sda_pull, .scl_pull);
   // ----
   // Helpers
   // ----
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task op(input logic rd, input logic [2:0] s, input logic [7:0] c, input logic [15:0] wd,
           input logic [15:0] exp, input logic nk);
      logic [31:0] q;
      logic        e;
      int          n;
      apb(1'b1, 8'h04, {16'h0, wd}, q, e);
      apb(1'b1, 8'h00, {16'h0, c, 1'b0, s, 2'b00, rd, 1'b1}, q, e);
      n = 0;
      do begin apb(1'b0, 8'h08, 32'h0, q, e); n++; end while (q[1] !== 1'b1 && n < 4000);
      chk("done", q[1], 1'b1);
      chk("nack", q[2], nk);
      if (rd && !nk) begin
         apb(1'b0, 8'h0c, 32'h0, q, e);
         chk("rdata", q, {16'h0, exp});
      end
      chk("idle", {scl, sda}, 2'b11);
   endtask
   function automatic logic [15:0] por(input int c);
      case (c)
         0: por = 16'h0017;
         5: por = TEMP;
         6: por = MAKER;
         7: por = PART;
         default: por = 16'h0000;
      endcase
   endfunction
   task end_sim;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task t_defaults;
      for (int c = 0; c < 15; c++) op(1'b1, SEL, c[7:0], 16'h0, por(c), 1'b0);
      $display("defaults done");
   endtask
   task t_writes;
      for (int c = 0; c < 15; c++) begin
         op(1'b0, SEL, c[7:0], {8'ha5, c[7:0]}, 16'h0, 1'b0);
         op(1'b1, SEL, c[7:0], 16'h0, (c >= 1 && c <= 4) ? {8'ha5, c[7:0]} : por(c), 1'b0);
      end
      $display("writes done");
   endtask
   task t_foreign;
      op(1'b0, 3'b101, 8'h01, 16'h0, 16'h0, 1'b1);
      op(1'b1, 3'b011, 8'h01, 16'h0, 16'h0, 1'b1);
      $display("foreign done");
   endtask
   task t_busy;
      logic [31:0] q;
      logic        e;
      int          n;
      apb(1'b1, 8'h04, 32'h0000_1357, q, e);
      apb(1'b1, 8'h00, {16'h0, 8'h02, 1'b0, SEL, 2'b00, 1'b0, 1'b1}, q, e);
      apb(1'b1, 8'h04, 32'h0000_ffff, q, e);
      apb(1'b0, 8'h08, 32'h0, q, e);
      chk("busy", q[0], 1'b1);
      n = 0;
      do begin apb(1'b0, 8'h08, 32'h0, q, e); n++; end while (q[1] !== 1'b1 && n < 4000);
      chk("busy end", q[1:0], 2'b10);
      op(1'b1, SEL, 8'h02, 16'h0, 16'h1357, 1'b0);
      $display("busy test done");
   endtask
   task t_slow;
      slow = 1'b1;
      op(1'b0, SEL, 8'h03, 16'hbeef, 16'h0, 1'b0);
      op(1'b1, SEL, 8'h03, 16'h0, 16'hbeef, 1'b0);
      slow = 1'b0;
      $display("slow done");
   endtask
   task t_unmapped;
      logic [31:0] q;
      logic        e;
      apb(1'b0, 8'h10, 32'h0, q, e);
      chk("rd data", q, 32'h0);
      chk("rd err", e, 1'b1);
      apb(1'b1, 8'h14, 32'hffff, q, e);
      chk("wr err", e, 1'b1);
      $display("unmapped done");
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      // About twice the expected run, still well inside the cycle budget.
      #640000;
      err_total++;
      end_sim;
   end
   initial begin
      {reset, psel, penable, pwrite, slow, paddr, pwdata} = {1'b1, 44'h0};
      err_total = 0;
      checked = 0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      t_defaults;
      t_writes;
      t_foreign;
      t_busy;
      t_slow;
      t_unmapped;
      end_sim;
   end
endmodule

/* sensor_model.sv */
// Behavioural temperature sensor slave on the two-wire bus.
`timescale 1ns/1ps
module sensor_model #(
   parameter logic [15:0] MAKER_ID   = 16'h1234, // Arbitrary value.
   parameter logic [15:0] PART_ID    = 16'h5678, // Arbitrary value.
   parameter logic [15:0] TEMP_VALUE = 16'h0190,
   parameter int          REFRESH_NS = 20000
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [2:0] pins,
   input  wire logic       slow,
   output logic            sda_pull,
   output logic            scl_pull
);
   logic [15:0] regs [0:15];
   logic [15:0] word;
   logic [7:0]  sh, cmd, msb;
   int          bitn, byten;
   logic        mine, rd;
   initial begin
      foreach (regs[i]) regs[i] = 16'h0000;
      regs[0] = 16'h0017;
      regs[6] = MAKER_ID;
      regs[7] = PART_ID;
      {sda_pull, scl_pull, mine, rd} = 4'h0;
   end
   // Refresh is much faster than real time so reads see the measured value.
   always #(REFRESH_NS) regs[5] = TEMP_VALUE;
   always @(negedge sda) if (scl === 1'b1) begin
      bitn = -1;
      byten = 0;
      mine = 1'b1;
      rd = 1'b0;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      mine = 1'b0;
      sda_pull = 1'b0;
   end
   always @(posedge scl) if (mine && bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
   always @(negedge scl) if (mine) begin
      if (slow) begin
         scl_pull = 1'b1;
         scl_pull <= #300 1'b0;
      end
      sda_pull = 1'b0;
      if (bitn == 8) begin
         bitn = 0;
         byten++;
      end else
         bitn++;
      if (bitn == 8 && (!rd || byten == 0)) begin
         if (byten == 0) begin
            mine = sh[7:1] == {4'h3, pins};
            rd = sh[0];
            word = (cmd < 8'h10) ? regs[cmd[3:0]] : 16'h0000;
         end else if (byten == 1)
            cmd = sh;
         else if (byten == 2)
            msb = sh;
         else if (byten == 3 && cmd inside {[8'h01:8'h04]})
            regs[cmd[3:0]] = {msb, sh};
         sda_pull = mine;
      end else if (rd && byten > 0 && byten < 3 && bitn < 8)
         sda_pull = !word[23 - 8 * byten - bitn];
   end
endmodule
